// >>> hdl/dsm_pkg.sv
// driver supply fault monitor: shared constants, command codes and types
// assumes one 10 MHz clock; measurements arrive already in linear format
package dsm_pkg;
	// command codes
	localparam logic [7:0] CMD_OV_LIMIT = 8'hf5;
	localparam logic [7:0] CMD_UV_LIMIT = 8'hf6;
	localparam logic [7:0] CMD_OV_RESP = 8'hf8;
	localparam logic [7:0] CMD_UV_RESP = 8'hf9;

	// reset values: limits chosen so that neither trips out of reset
	localparam logic [15:0] RST_OV_LIMIT = 16'h03ff;
	localparam logic [15:0] RST_UV_LIMIT = 16'h0000;
	localparam logic [7:0] RST_RESP = 8'h00;

	// response byte fields
	localparam int RESP_MODE_LSB = 6;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_LSB = 0;
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_RETRY = 2'h2;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// linear format fields
	localparam int LIN_EXP_LSB = 11;
	localparam int LIN_FRAC_BITS = 16;

	// warning scale in percent
	localparam int WARN_OV_PCT = 95;
	localparam int WARN_UV_PCT = 110;
	localparam int PCT_FULL = 100;

	// timing
	localparam int CLK_MHZ = 10;
	localparam int T_TICK_US = 1000;
	localparam int TICK_CYC = T_TICK_US * CLK_MHZ;
	localparam logic [8:0] T_RETRY_STEP_MS = 9'h023;

	localparam int CH_OV = 0;
	localparam int CH_UV = 1;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] retry;
		logic [2:0] delay;
	} dsm_resp_t;

	typedef struct packed {
		logic [7:0] code;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} dsm_cmd_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_WAIT = 3'b010,
		ST_LATCH = 3'b100
	} dsm_state_t;
endpackage

// >>> hdl/dsm_fault_monitor.sv
// driver supply fault monitor: limits, derived warnings, fault response and retry
// assumes a command layer that decodes PMBus into one-cycle read/write strobes,
// and a measurement front end on the same clock delivering linear-format samples
`timescale 1ns/100ps
module dsm_fault_monitor #(
	parameter int TICK_CYCLES = dsm_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command port
	input wire dsm_pkg::dsm_cmd_t cmd,
	output logic [15:0] cmd_rdata,
	output logic cmd_ack,
	// measurement
	input wire logic [15:0] meas_volt,
	input wire logic meas_valid,
	// power control
	input wire logic run_cmd,
	input wire logic bias_ok,
	input wire logic other_fault_off,
	input wire logic clear_faults,
	output logic out_en,
	// status
	output logic [1:0] fault_status,
	output logic [1:0] warn_status,
	// alert pin, open drain
	output logic smbalert_o,
	output logic smbalert_oe
);
	// linear word to signed fixed point with 16 fraction bits
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] lin);
		logic signed [47:0] m;
		logic [4:0] sh;
		m = {{37{lin[10]}}, lin[10:0]};
		// exponent plus 16, as unsigned: flip the sign bit
		sh = lin[15:dsm_pkg::LIN_EXP_LSB] ^ 5'h10;
		return m <<< sh;
	endfunction

	function automatic logic signed [47:0] scale_pct(input logic signed [47:0] v, input int pct);
		logic signed [63:0] p;
		p = 64'(v) * 64'(pct);
		p = p / 64'(dsm_pkg::PCT_FULL);
		return p[47:0];
	endfunction

	// configuration registers
	logic [15:0] ov_limit_r, ov_limit_nxt;
	logic [15:0] uv_limit_r, uv_limit_nxt;
	logic [7:0] ov_resp_r, ov_resp_nxt;
	logic [7:0] uv_resp_r, uv_resp_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic ack_r, ack_nxt;

	always_comb begin
		ov_limit_nxt = ov_limit_r;
		uv_limit_nxt = uv_limit_r;
		ov_resp_nxt = ov_resp_r;
		uv_resp_nxt = uv_resp_r;
		rdata_nxt = rdata_r;
		ack_nxt = cmd.wr | cmd.rd;
		if (cmd.wr) begin
			case (cmd.code)
				dsm_pkg::CMD_OV_LIMIT: ov_limit_nxt = cmd.wdata;
				dsm_pkg::CMD_UV_LIMIT: uv_limit_nxt = cmd.wdata;
				dsm_pkg::CMD_OV_RESP: ov_resp_nxt = cmd.wdata[7:0];
				dsm_pkg::CMD_UV_RESP: uv_resp_nxt = cmd.wdata[7:0];
				default: ;
			endcase
		end
		if (cmd.rd) begin
			case (cmd.code)
				dsm_pkg::CMD_OV_LIMIT: rdata_nxt = ov_limit_r;
				dsm_pkg::CMD_UV_LIMIT: rdata_nxt = uv_limit_r;
				dsm_pkg::CMD_OV_RESP: rdata_nxt = {8'h00, ov_resp_r};
				dsm_pkg::CMD_UV_RESP: rdata_nxt = {8'h00, uv_resp_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ov_limit_r <= dsm_pkg::RST_OV_LIMIT;
			uv_limit_r <= dsm_pkg::RST_UV_LIMIT;
			ov_resp_r <= dsm_pkg::RST_RESP;
			uv_resp_r <= dsm_pkg::RST_RESP;
			rdata_r <= 16'h0000;
			ack_r <= 1'b0;
		end else begin
			ov_limit_r <= ov_limit_nxt;
			uv_limit_r <= uv_limit_nxt;
			ov_resp_r <= ov_resp_nxt;
			uv_resp_r <= uv_resp_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
		end
	end

	assign cmd_rdata = rdata_r;
	assign cmd_ack = ack_r;

	// threshold comparison in fixed point; warnings need no register of their own
	logic signed [47:0] meas_fix, ov_fix, uv_fix, ov_warn_fix, uv_warn_fix;
	logic [1:0] fault_cond, warn_cond;

	always_comb begin
		meas_fix = lin_to_fix(meas_volt);
		ov_fix = lin_to_fix(ov_limit_r);
		uv_fix = lin_to_fix(uv_limit_r);
		ov_warn_fix = scale_pct(ov_fix, dsm_pkg::WARN_OV_PCT);
		uv_warn_fix = scale_pct(uv_fix, dsm_pkg::WARN_UV_PCT);
		fault_cond[dsm_pkg::CH_OV] = meas_valid & (meas_fix > ov_fix);
		fault_cond[dsm_pkg::CH_UV] = meas_valid & (meas_fix < uv_fix);
		warn_cond[dsm_pkg::CH_OV] = meas_valid & (meas_fix > ov_warn_fix);
		warn_cond[dsm_pkg::CH_UV] = meas_valid & (meas_fix < uv_warn_fix);
	end

	// sticky status; a new event in the clearing cycle wins
	logic [1:0] fault_st_r, fault_st_nxt;
	logic [1:0] warn_st_r, warn_st_nxt;

	always_comb begin
		fault_st_nxt = (clear_faults ? 2'h0 : fault_st_r) | fault_cond;
		warn_st_nxt = (clear_faults ? 2'h0 : warn_st_r) | warn_cond;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault_st_r <= 2'h0;
			warn_st_r <= 2'h0;
		end else begin
			fault_st_r <= fault_st_nxt;
			warn_st_r <= warn_st_nxt;
		end
	end

	assign fault_status = fault_st_r;
	assign warn_status = warn_st_r;
	// alert held low while any fault is unacknowledged
	assign smbalert_o = 1'b0;
	assign smbalert_oe = |fault_st_r;

	// millisecond enable
	logic [15:0] tick_cnt_r, tick_cnt_nxt;
	logic ms_tick;

	always_comb begin
		ms_tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));
		tick_cnt_nxt = ms_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// one response engine per fault type
	logic [1:0] hold, latched;
	logic running;
	assign running = run_cmd & bias_ok;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			dsm_pkg::dsm_resp_t resp;
			dsm_pkg::dsm_state_t st_r, st_nxt;
			logic [2:0] tries_r, tries_nxt;
			logic [8:0] ms_r, ms_nxt;
			logic [8:0] target;
			logic retry_spent;
			logic abort_other;

			assign resp = (i == dsm_pkg::CH_OV) ? ov_resp_r : uv_resp_r;

			always_comb begin
				target = 9'({6'h00, resp.delay} + 9'h001) * dsm_pkg::T_RETRY_STEP_MS;
				retry_spent = (resp.retry == dsm_pkg::RETRY_NONE) |
					((resp.retry != dsm_pkg::RETRY_FOREVER) & (tries_r >= resp.retry));
				abort_other = other_fault_off | latched[1 - i];
				st_nxt = st_r;
				tries_nxt = tries_r;
				ms_nxt = ms_r;
				case (st_r)
					dsm_pkg::ST_RUN: begin
						if (!running) begin
							tries_nxt = 3'h0;
						end else if (fault_cond[i] && resp.mode == dsm_pkg::MODE_RETRY) begin
							ms_nxt = 9'h000;
							st_nxt = retry_spent ? dsm_pkg::ST_LATCH : dsm_pkg::ST_WAIT;
						end
					end
					dsm_pkg::ST_WAIT: begin
						if (!running) begin
							st_nxt = dsm_pkg::ST_RUN;
							tries_nxt = 3'h0;
						end else if (abort_other) begin
							st_nxt = dsm_pkg::ST_LATCH;
						end else if (ms_r >= target) begin
							st_nxt = dsm_pkg::ST_RUN;
							tries_nxt = (tries_r == 3'h7) ? tries_r : tries_r + 3'h1;
						end else if (ms_tick) begin
							ms_nxt = ms_r + 9'h001;
						end
					end
					dsm_pkg::ST_LATCH: begin
						// a trip in the clearing cycle wins and keeps the output latched off
						if (clear_faults && !(fault_cond[i] && resp.mode == dsm_pkg::MODE_RETRY)) begin
							st_nxt = dsm_pkg::ST_RUN;
							tries_nxt = 3'h0;
						end
					end
					default: begin
						st_nxt = dsm_pkg::ST_LATCH;
					end
				endcase
			end

			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					st_r <= dsm_pkg::ST_RUN;
					tries_r <= 3'h0;
					ms_r <= 9'h000;
				end else begin
					st_r <= st_nxt;
					tries_r <= tries_nxt;
					ms_r <= ms_nxt;
				end
			end

			assign hold[i] = (st_r != dsm_pkg::ST_RUN);
			assign latched[i] = (st_r == dsm_pkg::ST_LATCH);
		end
	endgenerate

	// output enable: combinational term lets the fault cut it in the same edge
	logic out_en_r, out_en_nxt;
	logic [1:0] trip_now;

	always_comb begin
		trip_now[dsm_pkg::CH_OV] = fault_cond[dsm_pkg::CH_OV] &
			(ov_resp_r[7:dsm_pkg::RESP_MODE_LSB] == dsm_pkg::MODE_RETRY);
		trip_now[dsm_pkg::CH_UV] = fault_cond[dsm_pkg::CH_UV] &
			(uv_resp_r[7:dsm_pkg::RESP_MODE_LSB] == dsm_pkg::MODE_RETRY);
		out_en_nxt = running & ~other_fault_off & ~|hold & ~|trip_now;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_en_r <= 1'b0;
		end else begin
			out_en_r <= out_en_nxt;
		end
	end

	assign out_en = out_en_r;
endmodule

// >>> sim/dsm_fault_monitor_assertions.sv
// checker: port timing of the driver supply fault monitor
// assumes it is bound onto dsm_fault_monitor, one clock domain
`timescale 1ns/100ps
module dsm_fault_monitor_assertions #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command port
	input wire dsm_pkg::dsm_cmd_t cmd,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_ack,
	// control and status
	input wire logic meas_valid,
	input wire logic run_cmd,
	input wire logic bias_ok,
	input wire logic other_fault_off,
	input wire logic clear_faults,
	input wire logic out_en,
	input wire logic [1:0] fault_status,
	input wire logic smbalert_o,
	input wire logic smbalert_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_ack_follows: assert property ((cmd.wr || cmd.rd) |=> cmd_ack) else $error("no ack");
	chk_ack_cause: assert property (cmd_ack |-> $past(cmd.wr || cmd.rd)) else $error("stray ack");
	chk_rdata_hold: assert property (!cmd_ack |-> $stable(cmd_rdata)) else $error("rdata moved");
	chk_alert_or: assert property (smbalert_oe == |fault_status) else $error("alert wrong");
	chk_alert_low: assert property (!smbalert_o) else $error("alert level");
	chk_ov_cause: assert property ($rose(fault_status[0]) |-> $past(meas_valid)) else $error("ov flag");
	chk_uv_cause: assert property ($rose(fault_status[1]) |-> $past(meas_valid)) else $error("uv flag");
	chk_fault_sticky: assert property (fault_status[0] && !clear_faults |=> fault_status[0]) else $error("lost");
	chk_off_down: assert property ((!run_cmd || !bias_ok) |=> !out_en) else $error("still on");
	chk_drop_cause: assert property ($fell(out_en) |-> $past(meas_valid || !bias_ok || !run_cmd
		|| other_fault_off)) else $error("bad drop");
	cover property ($fell(out_en));
	cover property ($rose(out_en));
	cover property (fault_status == 2'h3);
endmodule
bind dsm_fault_monitor dsm_fault_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.mclk(mclk), .rst(rst),
	.cmd(cmd), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .meas_valid(meas_valid), .run_cmd(run_cmd),
	.bias_ok(bias_ok), .other_fault_off(other_fault_off), .clear_faults(clear_faults), .out_en(out_en),
	.fault_status(fault_status), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));

// >>> sim/dsm_host_model.sv
// host model: issues decoded command strobes to the monitor
// assumes an ack one cycle after each request is taken
`timescale 1ns/100ps
module dsm_host_model (
	// clock
	input wire logic mclk,
	// command port
	output dsm_pkg::dsm_cmd_t cmd,
	input wire logic cmd_ack,
	input wire logic [15:0] cmd_rdata
);
	initial cmd = '0;
	task automatic access(input logic [7:0] c, input logic w, input logic [15:0] d, output logic [15:0] q,
		output logic ok);
		@(posedge mclk);
		#10;
		cmd = '{code: c, wr: w, rd: !w, wdata: d};
		@(posedge mclk);
		#10;
		cmd.wr = 1'b0;
		cmd.rd = 1'b0;
		// released data shows garbage, not the last word
		cmd.wdata = ~d;
		q = cmd_rdata;
		ok = cmd_ack;
	endtask
endmodule

// >>> sim/dsm_fault_monitor_tb.sv
// testbench: registers, warnings, fault responses and retry timing
// assumes TICK_CYCLES of 4, so one retry step is 140 cycles
`timescale 1ns/100ps
module dsm_fault_monitor_tb;
	localparam int STEP = 35 * 4;
	logic mclk = 0, rst = 1, meas_valid = 0, bias_ok = 1, clear_faults = 0, ok, out_en, smbalert_o, smbalert_oe;
	logic run_cmd = 1, other_fault_off = 0;
	logic [15:0] meas_volt = 16'h004b, q, cmd_rdata;
	logic [1:0] fault_status, warn_status;
	logic cmd_ack;
	dsm_pkg::dsm_cmd_t cmd;
	int n_fail = 0, tests_run = 0;
	always #50 mclk = ~mclk;
	dsm_host_model host_u (.mclk(mclk), .cmd(cmd), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata));
	dsm_fault_monitor #(.TICK_CYCLES(4)) dut_u (.mclk(mclk), .rst(rst), .cmd(cmd), .cmd_rdata(cmd_rdata),
		.cmd_ack(cmd_ack), .meas_volt(meas_volt), .meas_valid(meas_valid), .run_cmd(run_cmd), .bias_ok(bias_ok),
		.other_fault_off(other_fault_off), .clear_faults(clear_faults), .out_en(out_en), .fault_status(fault_status),
		.warn_status(warn_status), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host_u.access(c, 1'b1, d, q, ok);
		chk(16'(ok), 16'h0001);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		host_u.access(c, 1'b0, 16'h0000, q, ok);
		chk(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask
	task automatic smp(input logic [15:0] v);
		tick(1);
		meas_volt = v;
		meas_valid = 1'b1;
		tick(1);
		meas_valid = 1'b0;
		meas_volt = 16'h004b;
	endtask
	task automatic clr;
		tick(1);
		clear_faults = 1'b1;
		tick(1);
		clear_faults = 1'b0;
		tick(1);
	endtask
	// out_en must come back within a few cycles of the programmed delay
	task automatic wait_on(input int n);
		int c;
		c = 0;
		while (out_en !== 1'b1 && c < 2000) begin
			tick(1);
			c++;
		end
		chk(16'(c >= n - 2 && c <= n + 4), 16'h0001);
	endtask
	task automatic t_regs;
		rd(dsm_pkg::CMD_OV_LIMIT, dsm_pkg::RST_OV_LIMIT);
		rd(dsm_pkg::CMD_OV_RESP, {8'h00, dsm_pkg::RST_RESP});
		// exponent -1, mantissa 200: still 100 V
		wr(dsm_pkg::CMD_OV_LIMIT, 16'hf8c8);
		wr(dsm_pkg::CMD_UV_LIMIT, 16'h0032);
		wr(dsm_pkg::CMD_UV_RESP, 16'hff00);
		wr(8'hf7, 16'h1234);
		rd(dsm_pkg::CMD_OV_LIMIT, 16'hf8c8);
		rd(dsm_pkg::CMD_UV_LIMIT, 16'h0032);
		rd(dsm_pkg::CMD_UV_RESP, 16'h0000);
		rd(8'hf7, 16'h0000);
		$display("regs done");
	endtask
	task automatic t_warn;
		smp(16'h005e);
		chk(16'({fault_status, warn_status}), 16'h0000);
		smp(16'h0038);
		chk(16'({fault_status, warn_status}), 16'h0000);
		smp(16'h0061);
		chk(16'({fault_status, warn_status}), 16'h0001);
		smp(16'h0035);
		chk(16'({fault_status, warn_status}), 16'h0003);
		smp(16'h0065);
		chk(16'({smbalert_oe, out_en, fault_status, warn_status}), 16'h0037);
		smp(16'h0031);
		chk(16'({smbalert_oe, out_en, fault_status, warn_status}), 16'h003f);
		clr;
		chk(16'({smbalert_oe, out_en, fault_status, warn_status}), 16'h0010);
		$display("warn done");
	endtask
	task automatic t_retry;
		wr(dsm_pkg::CMD_OV_RESP, 16'h0088);
		smp(16'h0065);
		chk(16'(out_en), 16'h0000);
		wait_on(STEP);
		smp(16'h0065);
		tick(400);
		chk(16'(out_en), 16'h0000);
		clr;
		chk(16'(out_en), 16'h0001);
		wr(dsm_pkg::CMD_UV_RESP, 16'h0080);
		smp(16'h0031);
		chk(16'({out_en, fault_status}), 16'h0002);
		tick(400);
		chk(16'(out_en), 16'h0000);
		clr;
		chk(16'(out_en), 16'h0001);
		$display("retry done");
	endtask
	task automatic t_forever;
		wr(dsm_pkg::CMD_OV_RESP, 16'h00b9);
		for (int i = 0; i < 8; i++) begin
			smp(16'h0065);
			wait_on(2 * STEP);
		end
		bias_ok = 1'b0;
		tick(2);
		chk(16'(out_en), 16'h0000);
		bias_ok = 1'b1;
		$display("forever done");
	endtask
	// endless retry is cut short by another shutdown and by a command off
	task automatic t_abort;
		smp(16'h0065);
		chk(16'(out_en), 16'h0000);
		other_fault_off = 1'b1;
		tick(1);
		other_fault_off = 1'b0;
		tick(400);
		chk(16'(out_en), 16'h0000);
		clr;
		chk(16'(out_en), 16'h0001);
		smp(16'h0065);
		run_cmd = 1'b0;
		tick(2);
		chk(16'(out_en), 16'h0000);
		run_cmd = 1'b1;
		tick(2);
		chk(16'(out_en), 16'h0001);
		clr;
		$display("abort done");
	endtask
	task automatic finish_test;
		$display("fails %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		tick(20);
		rst = 1'b0;
		t_regs;
		t_warn;
		t_retry;
		t_forever;
		t_abort;
		finish_test;
	end
	initial begin
		#1000000;
		n_fail++;
		finish_test;
	end
endmodule
